// *** sim/swm_partner.sv ***
`timescale 1ns/1ps

// Board side of the pins: strap resistors, serial memory and clock requests.
module swm_partner (
   input  wire logic       ee_data_out,
   input  wire logic       ee_data_oe,
   input  wire logic       ee_tie_low,
   input  wire logic       mem_drive,
   input  wire logic       mem_bit,
   input  wire logic [7:0] gpio_out,
   input  wire logic [7:0] gpio_oe,
   input  wire logic [7:0] board_gpio,
   input  wire logic [3:0] ps_out,
   input  wire logic [3:0] ps_oe,
   input  wire logic [3:0] clk_wanted,
   output logic            ee_data_in,
   output logic      [7:0] gpio_in,
   output logic      [3:0] refclk_request_n
);
   // The data line has a pull-up, so a released line reads high unless the
   // board ties the strap low; the memory drives only when it is told to.
   assign ee_data_in = ee_data_oe ? ee_data_out :
                       mem_drive ? mem_bit : !ee_tie_low;
   // A released general-purpose pin shows what the board puts on it.
   assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board_gpio);
   // A port whose clock may stop holds its request line high.
   assign refclk_request_n = (ps_oe & ps_out) | (~ps_oe & ~clk_wanted);
endmodule : swm_partner

// *** sim/swm_top_tb_top.sv ***
`timescale 1ns/1ps

module swm_top_tb_top
   import swm_pkg::*;
();
   typedef struct packed {logic [4:0] strap; logic [4:0] exp;} swm_row_t;
   logic       clk_sys, resetn, pwr_s, sel_s, proto_s, dbg_s, ee_tie_low;
   logic       valid, ld, ps, l1, smb, dbgm, mfg, scan_out, scan_oe;
   logic       ck_req, dq_req, drv_req, ee_rd, ee_clk, ee_in, ee_out, ee_oe;
   logic       mgmt_use, mem_drive, mem_bit;
   logic [7:0] gin, gout, goe, goe_c, gout_c, grd, board_gpio;
   logic [2:0] addr;
   logic [4:0] dsel;
   logic [3:0] rq_n, ps_out, ps_oe, ps_src, gate, clk_wanted;
   int         n_mismatch, num_checks;
   // Strap order is load, power, select, protocol, debug enable; the
   // expected order is load, power saving, substate, SMBus, debug mode.
   swm_row_t   rows [4] = '{'{5'h00, 5'h05}, '{5'h14, 5'h11},
                            '{5'h0b, 5'h0e}, '{5'h1f, 5'h1a}};

   swm_top i_dut (.clk_sys(clk_sys), .resetn(resetn),
      .power_saving_strap(pwr_s), .substate_or_status_select(sel_s),
      .mgmt_protocol_strap(proto_s), .debug_enable_strap(dbg_s),
      .straps_valid(valid), .eeprom_load_enable(ld),
      .power_save_enable(ps), .l1_substate_enable(l1),
      .mgmt_smbus_mode(smb), .debug_mode(dbgm), .ee_clock_req(ck_req),
      .ee_data_req(dq_req), .ee_drive_req(drv_req), .ee_data_rd(ee_rd),
      .eeprom_serial_clock(ee_clk), .eeprom_serial_data_in(ee_in),
      .eeprom_serial_data_out(ee_out), .eeprom_serial_data_oe(ee_oe),
      .mfg_test_mode(mfg), .scan_enable_out(scan_out),
      .scan_enable_oe(scan_oe), .gpio_in(gin), .gpio_out(gout),
      .gpio_oe(goe), .gpio_oe_ctrl(goe_c), .gpio_out_ctrl(gout_c),
      .gpio_rd(grd), .mgmt_bus_in_use(mgmt_use), .mgmt_addr_low(addr),
      .debug_select(dsel), .refclk_request_n_in(rq_n),
      .port_state_outputs(ps_out), .port_state_oe(ps_oe),
      .port_status_src(ps_src), .refclk_gate_off(gate));

   swm_partner i_board (.ee_data_out(ee_out), .ee_data_oe(ee_oe),
      .ee_tie_low(ee_tie_low), .mem_drive(mem_drive), .mem_bit(mem_bit),
      .gpio_out(gout), .gpio_oe(goe), .board_gpio(board_gpio),
      .ps_out(ps_out), .ps_oe(ps_oe), .clk_wanted(clk_wanted),
      .ee_data_in(ee_in), .gpio_in(gin), .refclk_request_n(rq_n));

   // The clock toggles every 2.5 ns, a period of 5 ns.
   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Compare one value and count the outcome.
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Inputs always change 1 ns after a rising edge, away from sampling.
   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   task test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // The whole run is well under 1000 cycles, so this only cuts a hang.
   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end

   // Each row resets with a new strap set, so reset is also hit mid-run.
   initial begin
      resetn = 1'h0;
      {pwr_s, sel_s, proto_s, dbg_s, ee_tie_low, mfg} = 6'h00;
      {ck_req, dq_req, drv_req, mgmt_use, mem_drive, mem_bit} = 6'h00;
      {goe_c, gout_c, board_gpio} = 24'h0000_00;
      {ps_src, clk_wanted} = 8'h00;
      n_mismatch = 0;
      num_checks = 0;
      foreach (rows[r]) begin
         {ee_tie_low, pwr_s, sel_s, proto_s, dbg_s} = rows[r].strap ^ 5'h10;
         {ck_req, dq_req, drv_req, mem_drive, mgmt_use} = 5'h1c;
         {goe_c, gout_c, board_gpio} = 24'hff00_b3;
         {ps_src, clk_wanted} = 8'h5e;
         resetn = 1'h0;
         step(20);
         chk("rst_valid", valid, 8'h00);
         chk("rst_scan_oe", scan_oe, 8'h01);
         chk("rst_ee_oe", ee_oe, 8'h00);
         resetn = 1'h1;
         step(1);
         chk("valid", valid, 8'h01);
         chk("ee_oe_first", ee_oe, 8'h00);
         step(1);
         chk("load", ld, rows[r].exp[4]);
         chk("psave", ps, rows[r].exp[3]);
         chk("substate", l1, rows[r].exp[2]);
         chk("smbus", smb, rows[r].exp[1]);
         chk("debug", dbgm, rows[r].exp[0]);
         chk("ee_oe", ee_oe, rows[r].exp[4]);
         chk("ee_clk", ee_clk, rows[r].exp[4]);
         chk("ee_out", ee_out, rows[r].exp[4]);
         drv_req = 1'h0;
         step(3);
         chk("ee_rd_hi", ee_rd, rows[r].exp[4]);
         chk("gpio_oe", goe, rows[r].exp[0] ? 8'he0 : 8'hff);
         chk("dbg_sel", dsel, rows[r].exp[0] ? 8'h13 : 8'h00);
         chk("gpio_rd", grd, rows[r].exp[0] ? 8'h13 : 8'h00);
         chk("ps_oe", ps_oe, rows[r].exp[2] ? 8'h00 : 8'h0f);
         chk("ps_out", ps_out & ps_oe, rows[r].exp[2] ? 8'h00 : 8'h05);
         chk("gate", gate, rows[r].exp[2] ? 8'h01 : 8'h00);
         {mem_drive, mem_bit} = 2'h2;
         step(3);
         chk("ee_rd_lo", ee_rd, 8'h00);
         {ee_tie_low, pwr_s, sel_s, proto_s, dbg_s} = ~rows[r].strap;
         mem_drive = 1'h0;
         step(3);
         chk("held", {ld, ps, l1, smb, dbgm}, rows[r].exp);
      end
      // The last row leaves memory loading on and debug mode off.
      mfg = 1'h1;
      step(1);
      chk("scan_oe_test", scan_oe, 8'h00);
      chk("scan_out", scan_out, 8'h00);
      mfg = 1'h0;
      step(1);
      chk("scan_oe_norm", scan_oe, 8'h01);
      {mgmt_use, board_gpio} = 9'h1a0;
      step(3);
      chk("gpio_oe_mgmt", goe, 8'h1f);
      chk("addr", addr, 8'h05);
      {mgmt_use, board_gpio} = 9'h040;
      step(3);
      chk("addr_hold", addr, 8'h05);
      chk("gpio_oe_all", goe, 8'hff);
      {goe_c, gout_c} = 16'h0f5a;
      step(1);
      chk("gpio_oe_b2b", goe, 8'h0f);
      chk("gpio_out", gout, 8'h5a);
      {drv_req, dq_req} = 2'h3;
      step(1);
      chk("ee_out_hi", ee_out, 8'h01);
      dq_req = 1'h0;
      step(1);
      chk("ee_out_lo", ee_out, 8'h00);
      ck_req = 1'h0;
      step(1);
      chk("ee_clk_lo", ee_clk, 8'h00);
      test_done();
   end
endmodule : swm_top_tb_top

// *** verilog/swm_gpio.sv ***
`timescale 1ns/1ps

module swm_gpio
   import swm_pkg::*;
#(
   parameter int N = NUM_GPIO
) (
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   input  wire logic [N-1:0]          gpio_in,
   input  wire logic [N-1:0]          gpio_oe_ctrl,
   input  wire logic [N-1:0]          gpio_out_ctrl,
   input  wire logic                  mgmt_bus_in_use,
   swm_strap_if.core                  sif,
   output logic      [N-1:0]          gpio_out,
   output logic      [N-1:0]          gpio_oe,
   output logic      [N-1:0]          gpio_rd,
   output logic      [SMB_ADDR_W-1:0] mgmt_addr_low,
   output logic      [DBG_SEL_W-1:0]  debug_select
);

   typedef struct packed {
      logic [N-1:0]          out;
      logic [N-1:0]          oe;
      logic [N-1:0]          rd;
      logic [SMB_ADDR_W-1:0] addr;
      logic [DBG_SEL_W-1:0]  dsel;
   } swm_gpio_reg_t;

   swm_gpio_reg_t st;
   swm_gpio_reg_t next_st;
   logic [N-1:0]  pin_taken;

   // A pin lent to a secondary function is forced input-only.
   for (genvar i = 0; i < N; i++) begin : g_bit
      assign pin_taken[i] =
         (mgmt_bus_in_use && i >= SMB_ADDR_LSB &&
          i < SMB_ADDR_LSB + SMB_ADDR_W) ||                        // [RULE_05]
         (sif.debug_mode && i >= DBG_SEL_LSB &&
          i < DBG_SEL_LSB + DBG_SEL_W);                            // [RULE_06]
   end

   // Software enables drive only on pins no secondary role claims.
   always_comb begin
      next_st      = st;
      next_st.out  = gpio_out_ctrl;
      next_st.oe   = gpio_oe_ctrl & ~pin_taken;                    // [RULE_04]
      next_st.rd   = gpio_in;
      next_st.addr = mgmt_bus_in_use ?
                     gpio_in[SMB_ADDR_LSB +: SMB_ADDR_W] : st.addr; // [RULE_05]
      next_st.dsel = sif.debug_mode ?
                     gpio_in[DBG_SEL_LSB +: DBG_SEL_W] : '0;       // [RULE_06]
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign gpio_out      = st.out;
   assign gpio_oe       = st.oe;
   assign gpio_rd       = st.rd;
   assign mgmt_addr_low = st.addr;
   assign debug_select  = st.dsel;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_gpio_oe;
      !mgmt_bus_in_use && !sif.debug_mode |=> gpio_oe == $past(gpio_oe_ctrl);
   endproperty
   a_gpio_oe: assert property (p_gpio_oe) // [RULE_04]
      else $error("GPIO enable does not follow control value.");

   property p_smb_addr;
      mgmt_bus_in_use |=> mgmt_addr_low == $past(gpio_in[7:5]) &&
                          gpio_oe[7:5] == 3'h0;
   endproperty
   a_smb_addr: assert property (p_smb_addr) // [RULE_05]
      else $error("Management address bits not taken from pins 7 to 5.");

   property p_dbg_sel;
      sif.debug_mode |=> debug_select == $past(gpio_in[4:0]) &&
                         gpio_oe[4:0] == 5'h00;
   endproperty
   a_dbg_sel: assert property (p_dbg_sel) // [RULE_06]
      else $error("Debug selection not taken from pins 4 to 0.");

   c_debug_sel: cover property (sif.debug_mode ##1 debug_select != 5'h00);

endmodule : swm_gpio

// *** verilog/swm_pkg.sv ***
package swm_pkg;

   // Pin group sizes and positions.
   localparam int NUM_GPIO      = 8;
   localparam int NUM_PORT      = 4;
   localparam int SMB_ADDR_LSB  = 5;
   localparam int SMB_ADDR_W    = 3;
   localparam int DBG_SEL_LSB   = 0;
   localparam int DBG_SEL_W     = 5;

   // Strap levels that select the named function.
   localparam logic EE_LOAD_LEVEL    = 1'b1;
   localparam logic PWRSAV_ON_LEVEL  = 1'b1;
   localparam logic SUBSTATE_LEVEL   = 1'b0;
   localparam logic SMBUS_LEVEL      = 1'b1;
   localparam logic DEBUG_LEVEL      = 1'b0;

   // Constant value driven on the full-scan pin outside manufacturing test.
   localparam logic SCAN_OUT_VAL     = 1'b0;

   // Reset values.
   localparam logic SCAN_OE_RST      = 1'b1;
   localparam logic PIN_OE_RST       = 1'b0;
   localparam logic PIN_OUT_RST      = 1'b0;
   localparam logic STRAP_RST        = 1'b0;

   // Strap sampler states, Gray along wait to run.
   typedef enum logic [1:0] {
      SWM_WAIT = 2'h0,
      SWM_RUN  = 2'h1
   } swm_strap_state_t;

endpackage : swm_pkg

// *** verilog/swm_strap.sv ***
`timescale 1ns/1ps

module swm_strap
   import swm_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic eeprom_data_strap,
   input  wire logic power_saving_strap,
   input  wire logic substate_or_status_select,
   input  wire logic mgmt_protocol_strap,
   input  wire logic debug_enable_strap,
   swm_strap_if.strap sif
);

   typedef struct packed {
      swm_strap_state_t state;
      logic             valid;
      logic             ee;
      logic             pws;
      logic             l1;
      logic             smb;
      logic             dbg;
   } swm_strap_reg_t;

   swm_strap_reg_t st;
   swm_strap_reg_t next_st;

   // Straps are caught on the first edge after reset release, never under
   // reset itself, and then frozen until the next reset.
   always_comb begin
      next_st = st;
      unique case (st.state)
         SWM_WAIT: begin
            next_st.ee    = (eeprom_data_strap == EE_LOAD_LEVEL);        // [RULE_01]
            next_st.pws   = (power_saving_strap == PWRSAV_ON_LEVEL);     // [RULE_07]
            next_st.l1    = (substate_or_status_select == SUBSTATE_LEVEL); // [RULE_08]
            next_st.smb   = (mgmt_protocol_strap == SMBUS_LEVEL);        // [RULE_09]
            next_st.dbg   = (debug_enable_strap == DEBUG_LEVEL);         // [RULE_10]
            next_st.valid = 1'b1;                                        // [RULE_12]
            next_st.state = SWM_RUN;
         end
         SWM_RUN: begin
            next_st.state = SWM_RUN;                                     // [RULE_12]
         end
         default: begin
            next_st.state = SWM_WAIT;
         end
      endcase
   end

   // Synchronous reset loads constants only.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st <= '{SWM_WAIT, STRAP_RST, STRAP_RST, STRAP_RST, STRAP_RST,
                 STRAP_RST, STRAP_RST};
      end else begin
         st <= next_st;
      end
   end

   assign sif.straps_valid   = st.valid;
   assign sif.eeprom_load_en = st.ee;
   assign sif.power_save_en  = st.pws;
   assign sif.l1_substate_en = st.l1;
   assign sif.smbus_mode     = st.smb;
   assign sif.debug_mode     = st.dbg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_ee_strap;
      $rose(st.valid) |-> st.ee == ($past(eeprom_data_strap) == EE_LOAD_LEVEL);
   endproperty
   a_ee_strap: assert property (p_ee_strap) // [RULE_01]
      else $error("EEPROM load strap latched wrong level.");

   property p_pws_strap;
      $rose(st.valid) |-> st.pws == $past(power_saving_strap);
   endproperty
   a_pws_strap: assert property (p_pws_strap) // [RULE_07]
      else $error("Power saving strap latched wrong level.");

   property p_proto_strap;
      $rose(st.valid) |-> st.smb == $past(mgmt_protocol_strap);
   endproperty
   a_proto_strap: assert property (p_proto_strap) // [RULE_09]
      else $error("Protocol select strap latched wrong level.");

   property p_dbg_strap;
      $rose(st.valid) |-> st.dbg == !$past(debug_enable_strap);
   endproperty
   a_dbg_strap: assert property (p_dbg_strap) // [RULE_10]
      else $error("Debug enable strap latched wrong level.");

   property p_strap_hold;
      st.valid |=> st.valid && $stable({st.ee, st.pws, st.l1, st.smb, st.dbg});
   endproperty
   a_strap_hold: assert property (p_strap_hold) // [RULE_12]
      else $error("Latched straps changed before reset.");

endmodule : swm_strap

// *** verilog/swm_strap_if.sv ***
`timescale 1ns/1ps

// Latched strap decisions, passed from the sampler to the pin logic.
interface swm_strap_if;
   logic straps_valid;
   logic eeprom_load_en;
   logic power_save_en;
   logic l1_substate_en;
   logic smbus_mode;
   logic debug_mode;

   modport strap (
      output straps_valid, eeprom_load_en, power_save_en,
      output l1_substate_en, smbus_mode, debug_mode
   );
   modport core (
      input straps_valid, eeprom_load_en, power_save_en,
      input l1_substate_en, smbus_mode, debug_mode
   );
endinterface : swm_strap_if

// *** verilog/swm_top.sv ***
`timescale 1ns/1ps

// Function
// (RULE_01) EEPROM data pin at init: low disables EEPROM load, high enables it.
// (RULE_02) After init, drive EEPROM clock and use data pin bidirectionally.
// (RULE_03) Full-scan pin is an output at 0 except in manufacturing test.
// (RULE_04) Each GPIO is input-only or bidirectional per the enable control.
// (RULE_05) With management bus in use, GPIO 7..5 give address bits 2..0.
// (RULE_06) In debug mode GPIO 4..0 carry the debug selection code.
// (RULE_07) Power saving strap high enables power saving, low disables it.
// (RULE_08) Select strap low enables L1.1 substate; high outputs port status.
// (RULE_09) Protocol strap low selects I2C, high selects SMBus.
// (RULE_10) Debug enable strap high is normal operation, low is debug mode.
// (RULE_11) In substate mode clock request pins gate reference clock and PLL.
// (RULE_12) Straps latch once at reset release and hold until next reset.
// (RULE_13) EEPROM data pin is never driven before its strap is sampled.

module swm_top
   import swm_pkg::*;
#(
   parameter int NGPIO = NUM_GPIO,
   parameter int NPORT = NUM_PORT
) (
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // Straps.
   input  wire logic                  power_saving_strap,
   input  wire logic                  substate_or_status_select,
   input  wire logic                  mgmt_protocol_strap,
   input  wire logic                  debug_enable_strap,
   // Strap decisions for the core.
   output logic                       straps_valid,
   output logic                       eeprom_load_enable,
   output logic                       power_save_enable,
   output logic                       l1_substate_enable,
   output logic                       mgmt_smbus_mode,
   output logic                       debug_mode,
   // EEPROM controller side.
   input  wire logic                  ee_clock_req,
   input  wire logic                  ee_data_req,
   input  wire logic                  ee_drive_req,
   output logic                       ee_data_rd,
   // EEPROM pins.
   output logic                       eeprom_serial_clock,
   input  wire logic                  eeprom_serial_data_in,
   output logic                       eeprom_serial_data_out,
   output logic                       eeprom_serial_data_oe,
   // Full-scan pin.
   input  wire logic                  mfg_test_mode,
   output logic                       scan_enable_out,
   output logic                       scan_enable_oe,
   // General-purpose pins and their control.
   input  wire logic [NGPIO-1:0]      gpio_in,
   output logic      [NGPIO-1:0]      gpio_out,
   output logic      [NGPIO-1:0]      gpio_oe,
   input  wire logic [NGPIO-1:0]      gpio_oe_ctrl,
   input  wire logic [NGPIO-1:0]      gpio_out_ctrl,
   output logic      [NGPIO-1:0]      gpio_rd,
   input  wire logic                  mgmt_bus_in_use,
   output logic      [SMB_ADDR_W-1:0] mgmt_addr_low,
   output logic      [DBG_SEL_W-1:0]  debug_select,
   // Shared clock request / port status pins.
   input  wire logic [NPORT-1:0]      refclk_request_n_in,
   output logic      [NPORT-1:0]      port_state_outputs,
   output logic      [NPORT-1:0]      port_state_oe,
   input  wire logic [NPORT-1:0]      port_status_src,
   output logic      [NPORT-1:0]      refclk_gate_off
);

   swm_strap_if sif ();

   // Strap sampler; the EEPROM data pin doubles as the load strap.
   swm_strap u_strap (
      .clk_sys                   (clk_sys),
      .resetn                    (resetn),
      .eeprom_data_strap         (eeprom_serial_data_in),
      .power_saving_strap        (power_saving_strap),
      .substate_or_status_select (substate_or_status_select),
      .mgmt_protocol_strap       (mgmt_protocol_strap),
      .debug_enable_strap        (debug_enable_strap),
      .sif                       (sif)
   );

   // General-purpose pins with their secondary roles.
   swm_gpio #(
      .N (NGPIO)
   ) u_gpio (
      .clk_sys         (clk_sys),
      .resetn          (resetn),
      .gpio_in         (gpio_in),
      .gpio_oe_ctrl    (gpio_oe_ctrl),
      .gpio_out_ctrl   (gpio_out_ctrl),
      .mgmt_bus_in_use (mgmt_bus_in_use),
      .sif             (sif),
      .gpio_out        (gpio_out),
      .gpio_oe         (gpio_oe),
      .gpio_rd         (gpio_rd),
      .mgmt_addr_low   (mgmt_addr_low),
      .debug_select    (debug_select)
   );

   // Strap decisions leave straight from the sampler's flip-flops.
   assign straps_valid       = sif.straps_valid;
   assign eeprom_load_enable = sif.eeprom_load_en;
   assign power_save_enable  = sif.power_save_en;
   assign l1_substate_enable = sif.l1_substate_en;
   assign mgmt_smbus_mode    = sif.smbus_mode;
   assign debug_mode         = sif.debug_mode;

   typedef struct packed {
      logic             ee_clk;
      logic             ee_out;
      logic             ee_oe;
      logic             ee_rd;
      logic             scan_out;
      logic             scan_oe;
      logic [NPORT-1:0] ps_out;
      logic [NPORT-1:0] ps_oe;
      logic [NPORT-1:0] gate_off;
   } swm_top_reg_t;

   swm_top_reg_t st;
   swm_top_reg_t next_st;
   logic         ee_active;

   // The EEPROM path opens only once the strap is in and asked for loading;
   // this also keeps the data pin quiet while it is still being sampled.
   assign ee_active = sif.straps_valid && sif.eeprom_load_en;

   always_comb begin
      next_st = st;

      // EEPROM clock and data, gated until the strap has been taken.
      next_st.ee_clk = ee_active ? ee_clock_req : PIN_OUT_RST;       // [RULE_02]
      next_st.ee_out = ee_active ? ee_data_req : PIN_OUT_RST;        // [RULE_02]
      next_st.ee_oe  = ee_active && ee_drive_req;                    // [RULE_13]
      next_st.ee_rd  = ee_active ? eeprom_serial_data_in : PIN_OUT_RST;

      // The scan pin is released only for manufacturing test.
      next_st.scan_out = SCAN_OUT_VAL;                               // [RULE_03]
      next_st.scan_oe  = !mfg_test_mode;                             // [RULE_03]

      // Shared pins: clock request inputs or port status outputs. Nothing
      // is driven before the straps settle, so a substate board never sees
      // a contending driver on its request lines.
      next_st.ps_out   = '0;
      next_st.ps_oe    = '0;
      next_st.gate_off = '0;
      if (sif.straps_valid) begin
         if (sif.l1_substate_en) begin
            // A deasserted (high) request stops refclk and PLL.
            next_st.gate_off = refclk_request_n_in;                  // [RULE_11]
         end else begin
            next_st.ps_out = port_status_src;                        // [RULE_08]
            next_st.ps_oe  = '1;                                     // [RULE_08]
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st <= '{PIN_OUT_RST, PIN_OUT_RST, PIN_OE_RST, PIN_OUT_RST,
                 SCAN_OUT_VAL, SCAN_OE_RST, '0, '0, '0};
      end else begin
         st <= next_st;
      end
   end

   assign eeprom_serial_clock    = st.ee_clk;
   assign eeprom_serial_data_out = st.ee_out;
   assign eeprom_serial_data_oe  = st.ee_oe;
   assign ee_data_rd             = st.ee_rd;
   assign scan_enable_out        = st.scan_out;
   assign scan_enable_oe         = st.scan_oe;
   assign port_state_outputs     = st.ps_out;
   assign port_state_oe          = st.ps_oe;
   assign refclk_gate_off        = st.gate_off;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_ee_clock;
      ee_active |=> eeprom_serial_clock == $past(ee_clock_req) &&
                    eeprom_serial_data_out == $past(ee_data_req);
   endproperty
   a_ee_clock: assert property (p_ee_clock) // [RULE_02]
      else $error("EEPROM clock or data does not follow the controller.");

   property p_ee_read;
      ee_active |=> ee_data_rd == $past(eeprom_serial_data_in);
   endproperty
   a_ee_read: assert property (p_ee_read) // [RULE_02]
      else $error("EEPROM read data not returned one cycle later.");

   property p_ee_no_drive;
      eeprom_serial_data_oe |-> $past(sif.straps_valid) &&
                                $past(sif.eeprom_load_en);
   endproperty
   a_ee_no_drive: assert property (p_ee_no_drive) // [RULE_13]
      else $error("EEPROM data driven before the strap was sampled.");

   property p_ee_quiet_first;
      $rose(resetn) |-> !eeprom_serial_data_oe ##1 !eeprom_serial_data_oe;
   endproperty
   a_ee_quiet_first: assert property (p_ee_quiet_first) // [RULE_13]
      else $error("EEPROM data driven during strap sampling.");

   property p_scan;
      !mfg_test_mode |=> scan_enable_oe && scan_enable_out == SCAN_OUT_VAL;
   endproperty
   a_scan: assert property (p_scan) // [RULE_03]
      else $error("Full-scan pin not driven low in normal operation.");

   property p_scan_test;
      mfg_test_mode |=> !scan_enable_oe;
   endproperty
   a_scan_test: assert property (p_scan_test) // [RULE_03]
      else $error("Full-scan pin still driven during manufacturing test.");

   property p_status;
      sif.straps_valid && !sif.l1_substate_en |=>
         port_state_oe == '1 && port_state_outputs == $past(port_status_src)
         && refclk_gate_off == '0;
   endproperty
   a_status: assert property (p_status) // [RULE_08]
      else $error("Port status not driven in status mode.");

   property p_substate;
      sif.straps_valid && sif.l1_substate_en |=>
         port_state_oe == '0 &&
         refclk_gate_off == $past(refclk_request_n_in);
   endproperty
   a_substate: assert property (p_substate) // [RULE_11]
      else $error("Clock request does not gate refclk in substate mode.");

   c_ee_transfer: cover property (ee_active ##1 eeprom_serial_data_oe);
   c_substate_exit: cover property (
      sif.l1_substate_en && refclk_gate_off[0] ##1 !refclk_gate_off[0]);
   c_status_mode: cover property (
      sif.straps_valid && !sif.l1_substate_en ##1 port_state_oe[0]);

endmodule : swm_top
